// File: psw_watchdog.v
// Pin-selectable watchdog supervisor core with kick monitoring and timeout pulse.
// Notes on behaviour
// - Kick held steady for timeout gives pulse.
// - Counter clears on pulse and on kick edges.
// - Rising and falling kick edges both count.
// - Regular kicks keep output high.
// - Expiry drives output low for pulse width.
// - Open-drain pulse lasts at least 100ms.
// - Push-pull pulse at least 1ms, driven both levels.
// - Open-drain only pulls low or releases.
// - Startup delay at power-up and select change.
// - No counting or pulse during startup delay.
// - After startup, time timeout and watch kicks.
// - Fixed variant: 60s startup, own timeout table.
// - Code 011 disables the watchdog.
// - First-edge codes wait for first kick.
// - Kicks ignored during pulse and startup.
// - Kicks ignored during 300us setup time.
// - Select change during pulse finishes old pulse.
// - Pulse end restarts a full timeout period.
`timescale 1ns/1ns
`include "psw_defines.vh"
module psw_watchdog
#(
   parameter VARIANT = `PSW_VAR_EQUAL,
   parameter OPEN_DRAIN = 1,
   parameter CLK_MHZ = `PSW_CLK_MHZ,
   parameter TICK_US = `PSW_TICK_US,
   parameter TW = `PSW_TW
)
(
   input wire core_clk,
   input wire rst_n,
   input wire kickInput,
   input wire timingSelectBit0,
   input wire timingSelectBit1,
   input wire timingSelectBit2,
   output reg timeoutPulseN_q,
   output reg timeoutPulseOe_q
);
   // Rounded-up conversion of a minimum time in us to whole ticks.
   function integer ceil_ticks;
      input integer us;
      input integer tickUs;
      begin
         ceil_ticks = (us + tickUs - 1) / tickUs;
      end
   endfunction

   // Cycles per tick; tick rate is a parameter so simulation can speed it up.
   localparam integer TICK_CYC = CLK_MHZ * TICK_US;
   localparam integer TICK_LAST_I = TICK_CYC - 1;
   localparam integer SETUP_I = ceil_ticks(`PSW_SETUP_US, TICK_US);
   localparam integer PULSE_I = OPEN_DRAIN ? ceil_ticks(`PSW_PULSE_OD_US, TICK_US) :
      ceil_ticks(`PSW_PULSE_PP_US, TICK_US);
   localparam [15:0] TICK_LAST = TICK_LAST_I[15:0];
   localparam [TW-1:0] SETUP_TICKS = SETUP_I[TW-1:0];
   localparam [TW-1:0] PULSE_TICKS = PULSE_I[TW-1:0];

   // True when one more tick brings the timer to its limit. Comparing with >=
   // also ends a phase at once if a smaller limit arrives in mid-count.
   function limit_hit;
      input [TW-1:0] count;
      input [TW-1:0] limit;
      begin
         limit_hit = (count + {{(TW-1){1'b0}}, 1'b1} >= limit);
      end
   endfunction

   reg [15:0] divCnt_q;
   reg tick_q;
   reg kickSync_q;
   reg kickPrev_q;
   reg [2:0] selSync_q;
   reg [2:0] selPrev_q;
   reg [2:0] phase_q;
   reg [TW-1:0] timer_q;
   reg selChangePend_q;
   wire [TW-1:0] delayTicks;
   wire [TW-1:0] timeoutTicks;
   wire kickEdge;
   wire selChange;

   psw_timing_rom #(.VARIANT(VARIANT), .TICK_US(TICK_US), .TW(TW)) uRom
   (
      .core_clk(core_clk),
      .sel(selPrev_q),
      .delayTicks_q(delayTicks),
      .timeoutTicks_q(timeoutTicks)
   );

   // Tick divider: one-cycle enable that paces every timing counter.
   always @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         divCnt_q <= 16'h0000;
         tick_q <= 1'b0;
      end
      else
      begin
         tick_q <= (divCnt_q == TICK_LAST);
         if (divCnt_q == TICK_LAST)
            divCnt_q <= 16'h0000;
         else
            divCnt_q <= divCnt_q + 16'h0001;
      end
   end

   // Inputs are synchronous; register once and compare with previous sample.
   always @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         kickSync_q <= 1'b0;
         kickPrev_q <= 1'b0;
         selSync_q <= 3'h0;
         selPrev_q <= 3'h0;
      end
      else
      begin
         kickSync_q <= kickInput;
         kickPrev_q <= kickSync_q;
         selSync_q <= {timingSelectBit2, timingSelectBit1, timingSelectBit0};
         selPrev_q <= selSync_q;
      end
   end

   // Either direction of kick change is a valid kick.
   assign kickEdge = kickSync_q ^ kickPrev_q;
   assign selChange = (selSync_q != selPrev_q);

   // Main phase machine. The timer counts ticks upward and compares to the limit,
   // so a fresh limit from the table applies without reloading the counter.
   always @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         phase_q <= `PSW_PH_SETUP; // power-up acts as a setting change
         timer_q <= {TW{1'b0}};
         selChangePend_q <= 1'b0;
      end
      else
      begin
         case (phase_q)
            `PSW_PH_SETUP:
            begin
               // Kicks are ignored here; the setting may keep moving.
               if (selChange)
                  timer_q <= {TW{1'b0}};
               else if (tick_q)
               begin
                  if (limit_hit(timer_q, SETUP_TICKS))
                  begin
                     timer_q <= {TW{1'b0}};
                     if (selPrev_q == `PSW_SEL_OFF)
                        phase_q <= `PSW_PH_OFF;
                     else if (delayTicks == `PSW_FIRST_EDGE)
                        phase_q <= `PSW_PH_FIRST;
                     else
                        phase_q <= `PSW_PH_START;
                  end
                  else
                     timer_q <= timer_q + 1'b1;
               end
            end
            `PSW_PH_START:
            begin
               // Kicks ignored and no pulse possible during startup.
               if (selChange)
               begin
                  phase_q <= `PSW_PH_SETUP;
                  timer_q <= {TW{1'b0}};
               end
               else if (tick_q)
               begin
                  if (limit_hit(timer_q, delayTicks))
                  begin
                     phase_q <= `PSW_PH_RUN;
                     timer_q <= {TW{1'b0}};
                  end
                  else
                     timer_q <= timer_q + 1'b1;
               end
            end
            `PSW_PH_FIRST:
            begin
               // No time limit: wait indefinitely for the first kick.
               if (selChange)
               begin
                  phase_q <= `PSW_PH_SETUP;
                  timer_q <= {TW{1'b0}};
               end
               else if (kickEdge)
               begin
                  phase_q <= `PSW_PH_RUN;
                  timer_q <= {TW{1'b0}};
               end
            end
            `PSW_PH_RUN:
            begin
               // Any kick edge restarts the period; a quiet period ends in a pulse.
               if (selChange)
               begin
                  phase_q <= `PSW_PH_SETUP;
                  timer_q <= {TW{1'b0}};
               end
               else if (kickEdge)
                  timer_q <= {TW{1'b0}};
               else if (tick_q)
               begin
                  if (limit_hit(timer_q, timeoutTicks))
                  begin
                     phase_q <= `PSW_PH_PULSE;
                     timer_q <= {TW{1'b0}};
                  end
                  else
                     timer_q <= timer_q + 1'b1;
               end
            end
            `PSW_PH_PULSE:
            begin
               // A select change is remembered and acted on after the pulse.
               if (selChange)
                  selChangePend_q <= 1'b1;
               if (tick_q)
               begin
                  if (limit_hit(timer_q, PULSE_TICKS))
                  begin
                     timer_q <= {TW{1'b0}};
                     selChangePend_q <= 1'b0;
                     if (selChangePend_q || selChange)
                        phase_q <= `PSW_PH_SETUP;
                     else
                        phase_q <= `PSW_PH_RUN;
                  end
                  else
                     timer_q <= timer_q + 1'b1; // kicks ignored
               end
            end
            `PSW_PH_OFF:
            begin
               // Disabled: nothing counts until the setting changes.
               timer_q <= {TW{1'b0}};
               if (selChange)
                  phase_q <= `PSW_PH_SETUP;
            end
            default:
            begin
               // An unused code falls back to the setup time, as after power-up.
               phase_q <= `PSW_PH_SETUP;
               timer_q <= {TW{1'b0}};
            end
         endcase
      end
   end

   // Output pin: open-drain only enables the driver to pull low; push-pull drives whenever out of reset.
   always @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         timeoutPulseN_q <= 1'b1;
         timeoutPulseOe_q <= 1'b0;
      end
      else
      begin
         timeoutPulseN_q <= (phase_q != `PSW_PH_PULSE);
         if (OPEN_DRAIN != 0)
            timeoutPulseOe_q <= (phase_q == `PSW_PH_PULSE);
         else
            timeoutPulseOe_q <= 1'b1;
      end
   end
endmodule // psw_watchdog

// File: psw_defines.vh
// Constants shared by the watchdog supervisor design files.
`ifndef PSW_DEFINES_VH
`define PSW_DEFINES_VH
// Variant selection codes.
`define PSW_VAR_EQUAL 2'h0
`define PSW_VAR_FIXED 2'h1
`define PSW_VAR_EXT 2'h2
// Select code that disables the watchdog.
`define PSW_SEL_OFF 3'h3
// Time base: one tick every 10 us, the common unit of every table entry.
`define PSW_CLK_MHZ 250
`define PSW_TICK_US 10
// Internal setup time after power-up or a select change, in us.
`define PSW_SETUP_US 300
// Output pulse widths in us for open-drain and push-pull outputs.
`define PSW_PULSE_OD_US 100000
`define PSW_PULSE_PP_US 1000
// Timer width in bits.
`define PSW_TW 23
// Table entries in us, each named by the minimum time it stands for.
`define PSW_T_30US 30
`define PSW_T_200US 200
`define PSW_T_1MS 1000
`define PSW_T_3MS 3000
`define PSW_T_10MS 10000
`define PSW_T_30MS 30000
`define PSW_T_100MS 100000
`define PSW_T_300MS 300000
`define PSW_T_1S 1000000
`define PSW_T_3S 3000000
`define PSW_T_10S 10000000
`define PSW_T_60S 60000000
// Special delay code: wait for the first kick.
`define PSW_FIRST_EDGE 23'h7f_ffff
// Phase codes.
`define PSW_PH_SETUP 3'h0
`define PSW_PH_START 3'h1
`define PSW_PH_RUN 3'h2
`define PSW_PH_PULSE 3'h3
`define PSW_PH_OFF 3'h4
`define PSW_PH_FIRST 3'h5
`endif

// File: psw_timing_rom.v
// Registered lookup of startup delay and timeout, in ticks, per variant and select code.
`timescale 1ns/1ns
`include "psw_defines.vh"
module psw_timing_rom
#(
   parameter VARIANT = 0,
   parameter TICK_US = `PSW_TICK_US,
   parameter TW = `PSW_TW
)
(
   input wire core_clk,
   input wire [2:0] sel,
   output reg [TW-1:0] delayTicks_q,
   output reg [TW-1:0] timeoutTicks_q
);
   // Convert microseconds to ticks, rounding a minimum up.
   // The tick size follows the parent's parameter, so a faster tick keeps the times right.
   function [TW-1:0] us2t;
      input integer us;
      integer t;
      begin
         t = (us + TICK_US - 1) / TICK_US;
         us2t = t[TW-1:0];
      end
   endfunction

   reg [TW-1:0] dly;
   reg [TW-1:0] tmo;

   // Table lookup; the timeout entry for the equal variant doubles as delay.
   always @*
   begin
      dly = us2t(`PSW_T_1MS);
      tmo = us2t(`PSW_T_1MS);
      case (VARIANT)
         `PSW_VAR_FIXED:
         begin
            dly = us2t(`PSW_T_60S);
            case (sel)
               3'h0: tmo = us2t(`PSW_T_1MS);
               3'h1: tmo = us2t(`PSW_T_3MS);
               3'h2: tmo = us2t(`PSW_T_10MS);
               3'h4: tmo = us2t(`PSW_T_100MS);
               3'h5: tmo = us2t(`PSW_T_300MS);
               3'h6: tmo = us2t(`PSW_T_3S);
               default: tmo = us2t(`PSW_T_60S);
            endcase
         end
         `PSW_VAR_EXT:
         begin
            case (sel)
               3'h0: dly = us2t(`PSW_T_3MS);
               3'h1: dly = us2t(`PSW_T_3S);
               3'h2: dly = us2t(`PSW_T_60S);
               3'h4: dly = us2t(`PSW_T_200US);
               3'h5: dly = `PSW_FIRST_EDGE;
               3'h6: dly = `PSW_FIRST_EDGE;
               default: dly = us2t(`PSW_T_60S);
            endcase
            case (sel)
               3'h0: tmo = us2t(`PSW_T_3MS);
               3'h1: tmo = us2t(`PSW_T_3S);
               3'h2: tmo = us2t(`PSW_T_1S);
               3'h4: tmo = us2t(`PSW_T_30US);
               3'h5: tmo = us2t(`PSW_T_1S);
               3'h6: tmo = us2t(`PSW_T_10S);
               default: tmo = us2t(`PSW_T_10S);
            endcase
         end
         default:
         begin
            case (sel)
               3'h0: tmo = us2t(`PSW_T_1MS);
               3'h1: tmo = us2t(`PSW_T_10MS);
               3'h2: tmo = us2t(`PSW_T_30MS);
               3'h4: tmo = us2t(`PSW_T_100MS);
               3'h5: tmo = us2t(`PSW_T_1S);
               3'h6: tmo = us2t(`PSW_T_10S);
               default: tmo = us2t(`PSW_T_60S);
            endcase
            dly = tmo;
         end
      endcase
   end

   // Registered outputs so the lookup stays off the timer's critical path.
   always @(posedge core_clk)
   begin
      delayTicks_q <= dly;
      timeoutTicks_q <= tmo;
   end
endmodule // psw_timing_rom

// File: psw_monitor.sv
// Pin-level assertions for the pin-selectable watchdog supervisor.
`timescale 1ns/1ns
`include "psw_defines.vh"
module psw_monitor
#(
   parameter OPEN_DRAIN = 1,
   parameter CLK_MHZ = `PSW_CLK_MHZ,
   parameter TICK_US = `PSW_TICK_US
)
(
   input wire core_clk,
   input wire rst_n,
   input wire kickInput,
   input wire timingSelectBit0,
   input wire timingSelectBit1,
   input wire timingSelectBit2,
   input wire timeoutPulseN_q,
   input wire timeoutPulseOe_q
);
   localparam integer TICK = CLK_MHZ * TICK_US;
   localparam integer PULSE = (OPEN_DRAIN != 0 ? `PSW_PULSE_OD_US : `PSW_PULSE_PP_US) * CLK_MHZ;
   localparam integer SETUP = `PSW_SETUP_US * CLK_MHZ;
   wire [2:0] sel = {timingSelectBit2, timingSelectBit1, timingSelectBit0};
   reg [31:0] lowCnt_q;
   reg [31:0] cfgAge_q;
   reg [31:0] offAge_q;
   reg [2:0] selPrev_q;
   // Ages run from the pins, ahead of the sync stages, so every bound errs on the safe side.
   always @(posedge core_clk)
   begin
      selPrev_q <= sel;
      lowCnt_q <= (!rst_n || timeoutPulseN_q) ? 32'h0000_0000 : lowCnt_q + 1;
      cfgAge_q <= (!rst_n || sel != selPrev_q) ? 32'h0000_0000 : cfgAge_q + 1;
      offAge_q <= (sel != `PSW_SEL_OFF) ? 32'h0000_0000 : offAge_q + 1;
   end
   // All checks share one clock and the synchronous reset.
   default clocking mcb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   reset_idle_a: assert property ($rose(rst_n) |-> timeoutPulseN_q && !timeoutPulseOe_q)
      else $error("outputs not idle after reset");
   push_pull_a: assert property ((OPEN_DRAIN == 0) && $past(rst_n) |-> timeoutPulseOe_q)
      else $error("push-pull output not driven");
   drain_only_a: assert property ((OPEN_DRAIN != 0) |-> timeoutPulseOe_q == !timeoutPulseN_q)
      else $error("open-drain output drives high");
   width_min_a: assert property ($rose(timeoutPulseN_q) |-> lowCnt_q >= PULSE - TICK - 2)
      else $error("timeout pulse too short");
   width_max_a: assert property (lowCnt_q <= PULSE + TICK + 2)
      else $error("timeout pulse too long");
   setup_quiet_a: assert property ($fell(timeoutPulseN_q) |-> cfgAge_q >= SETUP)
      else $error("pulse during setup time");
   off_quiet_a: assert property ($fell(timeoutPulseN_q) |-> offAge_q < 4)
      else $error("pulse while disabled");
   restart_gap_a: assert property ($rose(timeoutPulseN_q) |=> timeoutPulseN_q [*8])
      else $error("pulse restarted too soon");
   cover property ($fell(timeoutPulseN_q));
   cover property ($rose(timeoutPulseN_q));
   cover property (offAge_q == 100);
endmodule // psw_monitor

bind psw_watchdog psw_monitor #(.OPEN_DRAIN(OPEN_DRAIN), .CLK_MHZ(CLK_MHZ), .TICK_US(TICK_US))
   u_mon (.core_clk(core_clk), .rst_n(rst_n), .kickInput(kickInput),
   .timingSelectBit0(timingSelectBit0), .timingSelectBit1(timingSelectBit1),
   .timingSelectBit2(timingSelectBit2), .timeoutPulseN_q(timeoutPulseN_q),
   .timeoutPulseOe_q(timeoutPulseOe_q));

// File: psw_host_model.sv
// Host processor stand-in that toggles the kick pin at a steady rate.
`timescale 1ns/1ns
module psw_host_model
#(
   parameter PERIOD = 10
)
(
   input wire core_clk,
   input wire kickEn,
   output reg kickInput
);
   integer gap = 0;
   initial kickInput = 1'h0;
   // Toggling gives rising and falling kicks alike, well inside the shortest timeout.
   always @(posedge core_clk)
   begin
      gap <= (gap >= PERIOD - 1) ? 0 : gap + 1;
      if (kickEn && gap == PERIOD - 1)
         kickInput <= ~kickInput;
   end
endmodule // psw_host_model

// File: pin_selectable_watchdog_tb_top.sv
// Self-checking bench for the pin-selectable watchdog supervisor.
`timescale 1ns/1ns
`include "psw_defines.vh"
module pin_selectable_watchdog_tb_top;
   localparam integer TICK = 10;
   reg core_clk = 1'h0;
   reg rst_n = 1'h0;
   reg kickEn = 1'h0;
   reg [2:0] selCode = 3'h4;
   wire kickInput;
   wire pulseN;
   wire pulseOe;
   wire odN;
   wire odOe;
   integer badCount = 0;
   integer checks = 0;
   integer cycles = 0;
   integer i;
   integer fallAt;
   integer width;
   // Row layout: select code, host kicking, pulse expected within the window.
   reg [4:0] rows [0:5] = '{5'h11, 5'h12, 5'h0c, 5'h14, 5'h01, 5'h02};
   // A 1 MHz time base keeps a tick at ten cycles so the long tables fit the run.
   psw_watchdog #(.VARIANT(`PSW_VAR_EXT), .OPEN_DRAIN(0), .CLK_MHZ(1)) i_dut (
      .core_clk(core_clk), .rst_n(rst_n), .kickInput(kickInput),
      .timingSelectBit0(selCode[0]), .timingSelectBit1(selCode[1]),
      .timingSelectBit2(selCode[2]), .timeoutPulseN_q(pulseN), .timeoutPulseOe_q(pulseOe));
   psw_host_model #(.PERIOD(TICK)) i_host (.core_clk(core_clk), .kickEn(kickEn),
      .kickInput(kickInput));
   // Open-drain, equal-timing copy on the same pins covers the other output style.
   psw_watchdog #(.VARIANT(`PSW_VAR_EQUAL), .OPEN_DRAIN(1), .CLK_MHZ(1)) i_dut_od (
      .core_clk(core_clk), .rst_n(rst_n), .kickInput(kickInput),
      .timingSelectBit0(selCode[0]), .timingSelectBit1(selCode[1]),
      .timingSelectBit2(selCode[2]), .timeoutPulseN_q(odN), .timeoutPulseOe_q(odOe));
   always #2 core_clk = ~core_clk;
   // Cycle ceiling cuts a hang short.
   always @(posedge core_clk)
   begin
      cycles = cycles + 1;
      if (cycles == 60000)
      begin
         badCount = badCount + 1;
         wrap_up;
      end
   end
   task wrap_up;
   begin
      $display("checks %0d mismatches %0d", checks, badCount);
      if (badCount == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   end
   endtask
   task check_bit(input logic exp, input logic got, input string what);
   begin
      checks = checks + 1;
      if (got !== exp)
      begin
         badCount = badCount + 1;
         $display("CHECK FAILED at %0t: %s", $time, what);
      end
   end
   endtask
   task check_range(input integer lo, input integer hi, input integer got, input string what);
   begin
      checks = checks + 1;
      if (got < lo || got > hi)
      begin
         badCount = badCount + 1;
         $display("CHECK FAILED at %0t: %s is %0d", $time, what, got);
      end
   end
   endtask
   // Reset is held five cycles while the new setting and host behaviour settle.
   task restart(input [2:0] code, input logic kick);
   begin
      @(posedge core_clk);
      rst_n <= 1'h0;
      selCode <= code;
      kickEn <= kick;
      repeat (5) @(posedge core_clk);
      rst_n <= 1'h1;
   end
   endtask
   // Samples settle one step after each edge; a missing fall returns minus one.
   task watch_fall(input integer maxCyc, output integer at);
   begin
      at = -1;
      for (int n = 0; n < maxCyc && at < 0; n++)
      begin
         @(posedge core_clk);
         #1;
         if (pulseN === 1'h0)
            at = n;
      end
   end
   endtask
   task watch_rise(input integer maxCyc, output integer len);
   begin
      len = 0;
      while (pulseN === 1'h0 && len < maxCyc)
      begin
         @(posedge core_clk);
         #1;
         len = len + 1;
      end
   end
   endtask
   initial
   begin
      for (i = 0; i < 6; i = i + 1)
      begin
         restart(rows[i][4:2], rows[i][1]);
         watch_fall(7000, fallAt);
         check_bit(rows[i][0], fallAt >= 0, "pulse presence");
         $display("row %0d done", i);
      end
      restart(3'h4, 1'h0);
      #1;
      check_bit(1'h1, pulseN, "output high in reset");
      check_bit(1'h0, pulseOe, "enable low in reset");
      @(posedge core_clk);
      #1;
      check_bit(1'h1, pulseOe, "push-pull enable");
      // Setup 30 ticks, startup 20 ticks, then a 3-tick timeout of whole ticks: 53 ticks in all.
      watch_fall(800, fallAt);
      check_range(50 * TICK, 56 * TICK, fallAt, "first pulse time");
      $display("pulse timing test done");
      repeat (300) @(posedge core_clk);
      selCode <= `PSW_SEL_OFF;
      watch_rise(1200, width);
      check_range(98 * TICK, 102 * TICK, width + 300, "pulse width");
      watch_fall(1500, fallAt);
      check_bit(1'h1, fallAt < 0, "quiet when disabled");
      $display("select change in pulse test done");
      // Equal-timing open-drain copy, code 000: setup 30, startup 100, timeout 100 ticks.
      restart(3'h0, 1'h0);
      for (i = 0; i < 2400 && odN !== 1'h0; i = i + 1)
      begin
         @(posedge core_clk);
         #1;
      end
      check_range(230 * TICK, 231 * TICK, i, "open-drain pulse time");
      check_bit(1'h1, odOe, "open-drain pulls low");
      check_bit(1'h1, pulseN, "extended copy still quiet");
      $display("open-drain test done");
      wrap_up;
   end
endmodule // pin_selectable_watchdog_tb_top
